// ### src/lmd_scan_top.sv
// Purpose: Multiplexed LED matrix scan driver with its registers.
// Assumes: Option and power-down inputs are on ref_clk.
// Notes:   Pin function selects leave the port mux to the pad ring.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lmd_scan_top
    import lmd_pkg::*;
#(
    parameter int PHASE_TICKS = LMD_PHASE_DEF
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [8:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic [2:0] oscillator_option,
    input  wire logic       matrix_polarity_option,
    input  wire logic       power_down,
    input  wire logic       slow_osc_in_pd,
    output logic      [7:0] row_scan_pin,
    output logic      [7:0] column_drive_pin,
    output logic      [7:0] port1_led_select,
    output logic      [7:0] port3_led_select,
    output logic            lcd_enable
);

    lmd_ctl_if ctl ();

    // Software-visible state.
    logic [7:0] port1_sel_r;
    logic [7:0] port3_sel_r;
    logic       type_sel_r;
    logic       drive_on_r;
    logic       duty8_r;
    logic       div_high_r;
    logic [7:0] div_low_r;
    logic [7:0] disp_mem_r [LMD_MEM_DEPTH];

    // Scan state.
    lmd_state_t           state_r;
    lmd_state_t           state_nxt;
    logic [2:0]           row_idx_r;
    logic [2:0]           row_idx_nxt;
    logic [LMD_PHASE_W-1:0] phase_cnt_r;
    logic                 phase_end;
    logic                 run;
    logic [2:0]           last_row;
    logic [7:0]           cur_byte;
    logic                 pol;

    // Bus decode and read path.
    logic       mem_hit;
    logic [7:0] rd_val;
    logic [7:0] rdata_r;
    logic [7:0] row_r;
    logic [7:0] col_r;
    logic       lcd_en_r;

    assign mem_hit = (bus_addr & LMD_MEM_MASK) == LMD_MEM_BASE;
    assign pol     = matrix_polarity_option;

    // Divider and gap timer sit beside the sequencer.
    assign ctl.div_value  = {div_high_r, div_low_r};
    assign ctl.osc_option = oscillator_option;

    lmd_clk_div u_div (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ctl     (ctl)
    );

    lmd_ovl_timer u_ovl (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .ctl     (ctl)
    );

    // Port-1 pin function select.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port1_sel_r <= LMD_REG_RST;
        end else if (bus_wr && bus_addr == LMD_ADDR_P1SEL) begin
            port1_sel_r <= bus_wdata;
        end
    end

    // Port-3 pin function select.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            port3_sel_r <= LMD_REG_RST;
        end else if (bus_wr && bus_addr == LMD_ADDR_P3SEL) begin
            port3_sel_r <= bus_wdata;
        end
    end

    // Display control; the LCD-only bits are not kept here.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            type_sel_r <= LMD_REG_RST[LMD_CTRL_TYPE];
            drive_on_r <= LMD_REG_RST[LMD_CTRL_ON];
            duty8_r    <= LMD_REG_RST[LMD_CTRL_DUTY];
        end else if (bus_wr && bus_addr == LMD_ADDR_CTRL) begin
            type_sel_r <= bus_wdata[LMD_CTRL_TYPE];
            drive_on_r <= bus_wdata[LMD_CTRL_ON];
            duty8_r    <= bus_wdata[LMD_CTRL_DUTY];
        end
    end

    // Divider halves; they are stored even when the option ignores them.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            div_high_r <= LMD_REG_RST[LMD_DIVHI_BIT];
            div_low_r  <= LMD_REG_RST;
        end else if (bus_wr && bus_addr == LMD_ADDR_DIVHI) begin
            div_high_r <= bus_wdata[LMD_DIVHI_BIT];
        end else if (bus_wr && bus_addr == LMD_ADDR_DIVLO) begin
            div_low_r  <= bus_wdata;
        end
    end

    // Display memory, one byte per common; software may rewrite it
    // while scanning, and the new byte shows from the next output edge.
    for (genvar e = 0; e < LMD_MEM_DEPTH; e++) begin : g_mem
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                disp_mem_r[e] <= LMD_REG_RST;
            end else if (bus_wr && mem_hit && bus_addr[2:0] == 3'(e)) begin
                disp_mem_r[e] <= bus_wdata;
            end
        end
    end

    // Read mux; unmapped addresses and reserved bits read as zero.
    always_comb begin
        rd_val = 8'h00;
        if (mem_hit) begin
            rd_val = disp_mem_r[bus_addr[2:0]];
        end else begin
            case (bus_addr)
                LMD_ADDR_P1SEL: rd_val = port1_sel_r;
                LMD_ADDR_P3SEL: rd_val = port3_sel_r;
                LMD_ADDR_DIVLO: rd_val = div_low_r;
                LMD_ADDR_DIVHI: rd_val[LMD_DIVHI_BIT] = div_high_r;
                LMD_ADDR_CTRL: begin
                    rd_val[LMD_CTRL_TYPE] = type_sel_r;
                    rd_val[LMD_CTRL_ON]   = drive_on_r;
                    rd_val[LMD_CTRL_DUTY] = duty8_r;
                end
                default: rd_val = 8'h00;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (bus_rd) begin
            rdata_r <= rd_val;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // The driver runs only when selected, switched on and clocked.
    assign run = type_sel_r && drive_on_r &&
                 !(power_down && !slow_osc_in_pd);

    assign last_row  = duty8_r ? LMD_LAST_ROW8 : LMD_LAST_ROW4;
    assign cur_byte  = disp_mem_r[row_idx_r];
    assign phase_end = ctl.tick &&
                       (phase_cnt_r == LMD_PHASE_W'(PHASE_TICKS - 1));

    // Scan sequencer: drive one common, blank for the gap, step on.
    always_comb begin
        state_nxt     = state_r;
        row_idx_nxt   = row_idx_r;
        ctl.ovl_start = 1'b0;
        if (!run) begin
            state_nxt   = LMD_ST_IDLE;
            row_idx_nxt = 3'h0;
        end else begin
            case (state_r)
                LMD_ST_IDLE: begin
                    state_nxt = LMD_ST_DRIVE;
                end
                LMD_ST_DRIVE: begin
                    if (phase_end) begin
                        state_nxt     = LMD_ST_OVERLAP;
                        ctl.ovl_start = 1'b1;
                    end
                end
                LMD_ST_OVERLAP: begin
                    if (ctl.ovl_done) begin
                        state_nxt = LMD_ST_DRIVE;
                        // Ascending order, wrapping at the duty's last common.
                        if (row_idx_r >= last_row) begin
                            row_idx_nxt = 3'h0;
                        end else begin
                            row_idx_nxt = row_idx_r + 3'h1;
                        end
                    end
                end
                default: begin
                    state_nxt   = LMD_ST_IDLE;
                    row_idx_nxt = 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r   <= LMD_ST_IDLE;
            row_idx_r <= 3'h0;
        end else begin
            state_r   <= state_nxt;
            row_idx_r <= row_idx_nxt;
        end
    end

    // Phase length is counted in divided ticks, so the divider paces it.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            phase_cnt_r <= '0;
        end else if (state_r != LMD_ST_DRIVE || phase_end) begin
            phase_cnt_r <= '0;
        end else if (ctl.tick) begin
            phase_cnt_r <= phase_cnt_r + 1'b1;
        end
    end

    // Pin levels: off level equals the polarity option, on is its inverse.
    for (genvar i = 0; i < 8; i++) begin : g_pin
        always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
                row_r[i] <= LMD_PIN_RST[i];
                col_r[i] <= LMD_PIN_RST[i];
            end else begin
                row_r[i] <= (state_r == LMD_ST_DRIVE && row_idx_r == 3'(i))
                            ? !pol : pol;
                col_r[i] <= (state_r == LMD_ST_DRIVE && cur_byte[i])
                            ? !pol : pol;
            end
        end
    end

    // LCD is held off from the cycle after the LED side is selected.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lcd_en_r <= 1'b1;
        end else begin
            lcd_en_r <= !type_sel_r;
        end
    end

    assign bus_rdata        = rdata_r;
    assign row_scan_pin     = row_r;
    assign column_drive_pin = col_r;
    assign port1_led_select = port1_sel_r;
    assign port3_led_select = port3_sel_r;
    assign lcd_enable       = lcd_en_r;

    // Checks on the sequencer and pins.
    sequence s_gap_end;
        state_r == LMD_ST_OVERLAP && ctl.ovl_done && run;
    endsequence

    sequence s_sel_off;
        !type_sel_r ##1 !type_sel_r ##1 !type_sel_r;
    endsequence

    AST_LCD_EXCL: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_sel_off |-> row_scan_pin == {8{pol}} && lcd_enable)
        else $error("LED drives while LCD selected");
    AST_DRIVE_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        !drive_on_r |=> state_r == LMD_ST_IDLE)
        else $error("scan runs while switched off");
    AST_DUTY4_WRAP: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_gap_end and (!duty8_r && row_idx_r == 3'h3) |=> row_idx_r == 3'h0)
        else $error("quarter duty did not wrap");
    AST_DUTY8_STEP: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_gap_end and (duty8_r && row_idx_r == 3'h3) |=> row_idx_r == 3'h4)
        else $error("eighth duty stopped at four");
    AST_PD_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        power_down && !slow_osc_in_pd |=> state_r == LMD_ST_IDLE)
        else $error("scan survives power-down");
    AST_SEG_LEVEL: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == LMD_ST_DRIVE && $stable(pol)
        |=> column_drive_pin == ($past(cur_byte) ^ {8{pol}}))
        else $error("segment level wrong");
    AST_GAP_BLANK: assert property (@(posedge ref_clk) disable iff (!resetn)
        state_r == LMD_ST_OVERLAP ##1 $stable(pol)
        |-> row_scan_pin == {8{pol}})
        else $error("common active in gap");
    AST_P1_SEL: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus_wr && bus_addr == LMD_ADDR_P1SEL
        |=> port1_led_select == $past(bus_wdata))
        else $error("port-1 select not taken");
    AST_P3_SEL: assert property (@(posedge ref_clk) disable iff (!resetn)
        bus_wr && bus_addr == LMD_ADDR_P3SEL
        |=> port3_led_select == $past(bus_wdata))
        else $error("port-3 select not taken");
    AST_ORDER: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_gap_end and (row_idx_r < last_row)
        |=> state_r == LMD_ST_DRIVE && row_idx_r == $past(row_idx_r) + 3'h1)
        else $error("commons out of order");

    // A start from idle; the index was cleared when the driver stopped.
    sequence s_run_start;
        state_r == LMD_ST_IDLE && run;
    endsequence

    // Selecting the LED side must shut the LCD driver off one cycle later.
    AST_LCD_OFF: assert property (@(posedge ref_clk) disable iff (!resetn)
        type_sel_r |=> !lcd_enable)
        else $error("LCD left on with LED selected");
    // A restart must never resume in the middle of the sequence.
    AST_RUN_START: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_run_start |=> state_r == LMD_ST_DRIVE && row_idx_r == 3'h0)
        else $error("scan did not restart at first common");

endmodule
`default_nettype wire

// ### src/lmd_pkg.sv
// Purpose: Shared constants and types for the LED matrix scan driver.
// Assumes: 40 MHz ref_clk, 9-bit special-function address space.
// Notes:   Addresses are byte addresses on the plain register port.
package lmd_pkg;

    // Register and display memory addresses.
    localparam logic [8:0] LMD_ADDR_P1SEL  = 9'h09c;
    localparam logic [8:0] LMD_ADDR_P3SEL  = 9'h09e;
    localparam logic [8:0] LMD_ADDR_DIVHI  = 9'h0aa;
    localparam logic [8:0] LMD_ADDR_CTRL   = 9'h0ab;
    localparam logic [8:0] LMD_ADDR_DIVLO  = 9'h0ac;
    localparam logic [8:0] LMD_MEM_BASE    = 9'h1e0;
    localparam logic [8:0] LMD_MEM_MASK    = 9'h1f8;
    localparam int         LMD_MEM_DEPTH   = 8;

    // Field positions and reset values.
    localparam int         LMD_CTRL_TYPE   = 7;
    localparam int         LMD_CTRL_ON     = 6;
    localparam int         LMD_CTRL_DUTY   = 4;
    localparam int         LMD_DIVHI_BIT   = 0;
    localparam logic [7:0] LMD_REG_RST     = 8'h00;
    localparam logic [7:0] LMD_PIN_RST     = 8'h00;

    // Oscillator options under which the divider is honoured.
    localparam logic [2:0] LMD_OSC_OPT_A   = 3'h0;
    localparam logic [2:0] LMD_OSC_OPT_B   = 3'h5;
    localparam logic [2:0] LMD_OSC_OPT_C   = 3'h6;

    // Last common index for each duty.
    localparam logic [2:0] LMD_LAST_ROW4   = 3'h3;
    localparam logic [2:0] LMD_LAST_ROW8   = 3'h7;

    // Overlap time between common phases, in ns and in cycles.
    localparam int         LMD_CLK_NS      = 25;
    localparam int         LMD_OVL_MIN_NS  = 20000;
    localparam int         LMD_OVL_MAX_NS  = 40000;
    localparam int         LMD_OVL_CYC     = (LMD_OVL_MIN_NS + LMD_CLK_NS - 1) / LMD_CLK_NS;
    localparam int         LMD_OVL_MAX_CYC = LMD_OVL_MAX_NS / LMD_CLK_NS;
    localparam int         LMD_OVL_W       = 11;

    // Divided-clock ticks per common phase.
    localparam int         LMD_PHASE_DEF   = 64;
    localparam int         LMD_PHASE_W     = 8;

    typedef enum logic [1:0] {
        LMD_ST_IDLE    = 2'b00,
        LMD_ST_DRIVE   = 2'b01,
        LMD_ST_OVERLAP = 2'b10
    } lmd_state_t;

endpackage

// ### src/lmd_ctl_if.sv
// Purpose: Carries divider and overlap timer signals inside the driver.
// Assumes: All members live on ref_clk.
// Notes:   One driver per member, named by the modports.
`timescale 1ns/1ps
`default_nettype none
interface lmd_ctl_if;
    logic [8:0] div_value;
    logic [2:0] osc_option;
    logic       tick;
    logic       ovl_start;
    logic       ovl_done;
    logic       ovl_busy;

    modport core (output div_value, output osc_option, output ovl_start,
                  input tick, input ovl_done, input ovl_busy);
    modport div  (input div_value, input osc_option, output tick);
    modport tmr  (input ovl_start, output ovl_done, output ovl_busy);
endinterface
`default_nettype wire

// ### src/lmd_clk_div.sv
// Purpose: Makes the scan clock enable from the 9-bit divider value.
// Assumes: Oscillator option is static while the driver runs.
// Notes:   Values 0 and 1 both give a tick every cycle.
`timescale 1ns/1ps
`default_nettype none
module lmd_clk_div
    import lmd_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    lmd_ctl_if.div    ctl
);
    logic [8:0] cnt_r;
    logic       avail;
    logic       bypass;
    logic       wrap;

    // Other oscillator options leave the divider without effect.
    assign avail  = (ctl.osc_option == LMD_OSC_OPT_A) ||
                    (ctl.osc_option == LMD_OSC_OPT_B) ||
                    (ctl.osc_option == LMD_OSC_OPT_C);
    assign bypass = !avail || (ctl.div_value <= 9'h001);
    // A shrunken divider value ends the count at once, not after a wrap.
    assign wrap   = cnt_r >= (ctl.div_value - 9'h001);
    assign ctl.tick = bypass || wrap;

    // Free count of reference cycles within one divided period.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 9'h000;
        end else if (bypass || wrap) begin
            cnt_r <= 9'h000;
        end else begin
            cnt_r <= cnt_r + 9'h001;
        end
    end

    AST_DIV_BYPASS: assert property (@(posedge ref_clk) disable iff (!resetn)
        !avail |-> ctl.tick) else $error("divider not bypassed");
    // A change of option or value may legally give an early tick, so both must hold still.
    AST_DIV_SPACE: assert property (@(posedge ref_clk) disable iff (!resetn)
        (ctl.tick && !bypass && cnt_r != 9'h000) ##1
        ($stable(ctl.div_value) && $stable(ctl.osc_option))
        |-> !ctl.tick) else $error("divided ticks too close");
endmodule
`default_nettype wire

// ### src/lmd_ovl_timer.sv
// Purpose: Times the blank gap between two common phases.
// Assumes: Start is a one-cycle pulse from the scan sequencer.
// Notes:   A new start restarts the gap and cancels a pending done.
`timescale 1ns/1ps
`default_nettype none
module lmd_ovl_timer
    import lmd_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    lmd_ctl_if.tmr    ctl
);
    logic [LMD_OVL_W-1:0] cnt_r;
    logic                 busy_r;
    logic                 done_r;
    logic [LMD_OVL_W-1:0] span_r;

    assign ctl.ovl_busy = busy_r;
    assign ctl.ovl_done = done_r;

    // Count down the least overlap; done follows the last busy cycle.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else if (ctl.ovl_start) begin
            cnt_r  <= LMD_OVL_W'(LMD_OVL_CYC - 1);
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end else if (busy_r) begin
            cnt_r  <= cnt_r - 1'b1;
            busy_r <= (cnt_r != '0);
            done_r <= (cnt_r == '0);
        end else begin
            done_r <= 1'b0;
        end
    end

    // Cycles seen busy since the last start, for checking only.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            span_r <= '0;
        end else if (ctl.ovl_start) begin
            span_r <= '0;
        end else if (busy_r) begin
            span_r <= span_r + 1'b1;
        end
    end

    AST_OVL_SPAN: assert property (@(posedge ref_clk) disable iff (!resetn)
        done_r |-> (span_r == LMD_OVL_W'(LMD_OVL_CYC)) &&
                   (span_r <= LMD_OVL_W'(LMD_OVL_MAX_CYC)))
        else $error("overlap gap length wrong");
endmodule
`default_nettype wire

// ### test/lmd_matrix_model.sv
// Purpose: Behavioural LED matrix hanging on the common and segment lines.
// Assumes: Lines are registered on ref_clk and settle before the next edge.
// Notes:   lit_row is 8 when the matrix is dark and 9 when commons overlap.
`timescale 1ns/1ps
`default_nettype none
module lmd_matrix_model (
    input  wire logic       ref_clk,
    input  wire logic       polarity,
    input  wire logic [7:0] row_scan_pin,
    input  wire logic [7:0] column_drive_pin,
    output logic      [3:0] lit_row,
    output logic      [7:0] lit_seg,
    output int              off_cycles,
    output int              on_cycles
);
    logic [7:0] rows_on;

    // The lit level is the inverse of the polarity option, so fold it out first.
    always_comb begin
        rows_on = row_scan_pin ^ {8{polarity}};
        lit_seg = column_drive_pin ^ {8{polarity}};
        lit_row = ($countones(rows_on) > 1) ? 4'h9 : 4'h8;
        for (int i = 0; i < 8; i++) begin
            if (rows_on == (8'h01 << i)) begin
                lit_row = 4'(i);
            end
        end
    end

    // Dark and lit spans are counted so that phases and gaps can be timed.
    always_ff @(posedge ref_clk) begin
        if (lit_row == 4'h8) begin
            off_cycles <= off_cycles + 1;
            on_cycles  <= 0;
        end else begin
            on_cycles  <= on_cycles + 1;
            off_cycles <= 0;
        end
    end
endmodule
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the LED matrix scan driver.
// Assumes: Small phase length so that a full scan stays short.
// Notes:   Phase and gap lengths are read from the matrix model counters.
`timescale 1ns/1ps
`default_nettype none
module tb
    import lmd_pkg::*;
();
    localparam int PH      = 2;
    localparam int GAP_MIN = LMD_OVL_MIN_NS / LMD_CLK_NS;
    localparam int GAP_MAX = LMD_OVL_MAX_NS / LMD_CLK_NS;
    logic       ref_clk = 1'b0;
    logic       resetn = 1'b0;
    logic [8:0] bus_addr = 9'h000;
    logic [7:0] bus_wdata = 8'h00;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [2:0] osc = 3'h0;
    logic       pol = 1'b0;
    logic       pd = 1'b0;
    logic       slow = 1'b0;
    logic [7:0] bus_rdata, rows, cols, p1s, p3s, lit_seg;
    logic       lcd_en;
    logic [3:0] lit_row;
    int         off_cycles, on_cycles;
    int         n_errors = 0;
    int         comparisons = 0;
    logic [8:0] regs [5] = '{LMD_ADDR_P1SEL, LMD_ADDR_P3SEL, LMD_ADDR_DIVHI, LMD_ADDR_CTRL,
                             LMD_ADDR_DIVLO};
    logic [7:0] wv [5] = '{8'ha5, 8'h5a, 8'hff, 8'hff, 8'h3c};
    logic [7:0] ev [5] = '{8'ha5, 8'h5a, 8'h01, 8'hd0, 8'h3c};

    lmd_scan_top #(.PHASE_TICKS(PH)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .oscillator_option(osc),
        .matrix_polarity_option(pol), .power_down(pd), .slow_osc_in_pd(slow),
        .row_scan_pin(rows), .column_drive_pin(cols), .port1_led_select(p1s),
        .port3_led_select(p3s), .lcd_enable(lcd_en));

    lmd_matrix_model u_led (
        .ref_clk(ref_clk), .polarity(pol), .row_scan_pin(rows), .column_drive_pin(cols),
        .lit_row(lit_row), .lit_seg(lit_seg), .off_cycles(off_cycles), .on_cycles(on_cycles));

    // Free-running 40 MHz clock.
    always #12.5 ref_clk = ~ref_clk;

    task automatic finish_test;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rchk(input logic [8:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, e);
    endtask

    function automatic logic [7:0] mem_val(input int k);
        return 8'h0c ^ (8'h01 << k);
    endfunction

    // Waits for one lit phase; a stuck matrix shows up as a dark index.
    task automatic phase(output int i, output logic [7:0] s, output int n, output int g);
        int t;
        t = 0;
        g = 0;
        n = 0;
        while (lit_row > 4'h7 && t < 4000) begin
            g = off_cycles;
            @(posedge ref_clk);
            #1;
            t++;
        end
        i = int'(lit_row);
        s = lit_seg;
        while (lit_row == i[3:0] && t < 4000) begin
            n = on_cycles;
            @(posedge ref_clk);
            #1;
            t++;
        end
    endtask

    // The divider runs free, so the first tick of a phase lands anywhere in its period:
    // a phase lasts more than PH-1 and at most PH divided periods; len is one short.
    task automatic scan(input int nrows, input int div);
        int idx, len, gap;
        logic [7:0] seg;
        for (int k = 0; k <= nrows; k++) begin
            phase(idx, seg, len, gap);
            chk(idx[7:0], 8'(k % nrows));
            chk(seg, mem_val(k % nrows));
            chk(8'(len + 1 > (PH - 1) * div && len + 1 <= PH * div), 8'h01);
            if (k > 0) chk(8'(gap + 1 >= GAP_MIN && gap + 1 <= GAP_MAX), 8'h01);
        end
    endtask

    // Off level must hold on every line for a span longer than one gap.
    task automatic dark;
        int t;
        t = 0;
        repeat (4) @(posedge ref_clk);
        repeat (900) begin
            @(posedge ref_clk);
            #1;
            if (rows !== {8{pol}} || cols !== {8{pol}}) t++;
        end
        chk(8'(t != 0), 8'h00);
    endtask

    // Main sequence of register, scan and power-down scenarios.
    initial begin
        int idx, len, gap;
        logic [7:0] seg;
        repeat (10) @(posedge ref_clk);
        chk({7'h00, lcd_en}, 8'h01);
        resetn <= 1'b1;
        foreach (regs[i]) rchk(regs[i], 8'h00);
        dark();
        foreach (regs[i]) begin
            wr(regs[i], wv[i]);
            rchk(regs[i], ev[i]);
        end
        chk(p1s, 8'ha5);
        chk(p3s, 8'h5a);
        chk({7'h00, lcd_en}, 8'h00);
        rchk(9'h0ad, 8'h00);
        wr(LMD_ADDR_CTRL, 8'h40);
        // The select lands at the write edge and the LCD enable follows one edge later.
        repeat (2) @(posedge ref_clk);
        chk({7'h00, lcd_en}, 8'h01);
        dark();
        wr(LMD_ADDR_DIVHI, 8'h00);
        wr(LMD_ADDR_DIVLO, 8'h00);
        for (int k = 0; k < LMD_MEM_DEPTH; k++) wr(LMD_MEM_BASE + 9'(k), mem_val(k));
        for (int k = 0; k < LMD_MEM_DEPTH; k++) rchk(LMD_MEM_BASE + 9'(k), mem_val(k));
        wr(LMD_ADDR_CTRL, 8'hc0);
        scan(4, 1);
        wr(LMD_ADDR_CTRL, 8'h80);
        dark();
        wr(LMD_ADDR_CTRL, 8'hd0);
        scan(8, 1);
        @(posedge ref_clk);
        slow <= 1'b1;
        pd   <= 1'b1;
        phase(idx, seg, len, gap);
        chk(8'(idx < 8), 8'h01);
        @(posedge ref_clk);
        slow <= 1'b0;
        dark();
        @(posedge ref_clk);
        pd <= 1'b0;
        wr(LMD_ADDR_CTRL, 8'h80);
        wr(LMD_ADDR_DIVLO, 8'h0a);
        for (int o = 0; o < 8; o++) begin
            osc <= 3'(o);
            wr(LMD_ADDR_CTRL, 8'hc0);
            scan(4, (o == 0 || o == 5 || o == 6) ? 10 : 1);
            wr(LMD_ADDR_CTRL, 8'h80);
        end
        osc <= 3'h5;
        wr(LMD_ADDR_DIVHI, 8'h01);
        wr(LMD_ADDR_DIVLO, 8'h00);
        wr(LMD_ADDR_CTRL, 8'hc0);
        scan(4, 256);
        wr(LMD_ADDR_CTRL, 8'h80);
        wr(LMD_ADDR_DIVHI, 8'h00);
        pol <= 1'b1;
        dark();
        wr(LMD_ADDR_CTRL, 8'hc0);
        scan(4, 1);
        finish_test();
    end

    // Watchdog sized well past the longest expected run.
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end
endmodule
`default_nettype wire
